// ==== sbc_regs.svh ====
// constants of the synchronous burst cache sram
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH
`define SBC_ADDR_W 16
`define SBC_DATA_W 18
`define SBC_DEPTH 65536
`define SBC_LANE_W 9
`define SBC_LANES 2
`define SBC_CNT_W 2
`define SBC_BUF_DEPTH 2
`define SBC_BASE_RST 16'h0000
`define SBC_CNT_RST 2'h0
`define SBC_WORD_RST 18'h00000
`define SBC_READ_LAT 2
`endif

// ==== sbc_pkg.sv ====
// types of the synchronous burst cache sram
package sbc_pkg;
    typedef enum logic [2:0] {
        SBC_OP_NONE = 3'b000,
        SBC_OP_DESEL = 3'b001,
        SBC_OP_RD_EXT = 3'b010,
        SBC_OP_WR_EXT = 3'b011,
        SBC_OP_RD_NEXT = 3'b100,
        SBC_OP_WR_NEXT = 3'b101,
        SBC_OP_RD_CUR = 3'b110,
        SBC_OP_WR_CUR = 3'b111
    } sbc_op_t;
    typedef enum logic [0:0] {
        SBC_ST_IDLE = 1'b0,
        SBC_ST_BURST = 1'b1
    } sbc_st_t;
endpackage

// ==== sbc_stream_if.sv ====
// valid/ready word stream between the array and the read buffer
`timescale 1ns/100ps
`include "sbc_regs.svh"
interface sbc_stream_if;
    logic valid;
    logic ready;
    logic [`SBC_DATA_W-1:0] data;
    modport src (
        output valid,
        output data,
        input ready
    );
    modport snk (
        input valid,
        input data,
        output ready
    );
endinterface

// ==== sbc_buf.sv ====
// two-entry read data buffer
`timescale 1ns/100ps
`include "sbc_regs.svh"
module sbc_buf (
    input wire logic ref_clk,
    input wire logic reset_n,
    sbc_stream_if.snk wr_side,
    sbc_stream_if.src rd_side
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic full_r;
    logic full_nxt;
    logic [`SBC_DATA_W-1:0] head_r;
    logic [`SBC_DATA_W-1:0] head_nxt;
    logic [`SBC_DATA_W-1:0] tail_r;
    logic [`SBC_DATA_W-1:0] tail_nxt;
    logic push;
    logic pop;
    logic valid_r;
    logic valid_nxt;

    // ready from a flop so the source sees no path through the drain side
    assign wr_side.ready = ~full_r;
    assign rd_side.valid = valid_r;
    assign rd_side.data = head_r;

    always_comb begin
        push = wr_side.valid & ~full_r;
        pop = rd_side.ready & (cnt_r != 2'h0);
        cnt_nxt = cnt_r;
        head_nxt = head_r;
        tail_nxt = tail_r;
        case ({push, pop})
            2'b10: begin
                cnt_nxt = cnt_r + 2'h1;
                if (cnt_r == 2'h0) begin
                    head_nxt = wr_side.data;
                end else begin
                    tail_nxt = wr_side.data;
                end
            end
            2'b01: begin
                cnt_nxt = cnt_r - 2'h1;
                head_nxt = tail_r;
            end
            2'b11: begin
                if (cnt_r == 2'h1) begin
                    head_nxt = wr_side.data;
                end else begin
                    head_nxt = tail_r;
                    tail_nxt = wr_side.data;
                end
            end
            default: begin
                cnt_nxt = cnt_r;
            end
        endcase
        full_nxt = (cnt_nxt == 2'(`SBC_BUF_DEPTH));
        valid_nxt = (cnt_nxt != 2'h0);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 2'h0;
            full_r <= 1'b0;
            valid_r <= 1'b0;
            head_r <= `SBC_WORD_RST;
            tail_r <= `SBC_WORD_RST;
        end else begin
            cnt_r <= cnt_nxt;
            full_r <= full_nxt;
            valid_r <= valid_nxt;
            head_r <= head_nxt;
            tail_r <= tail_nxt;
        end
    end
endmodule

// ==== sbc_sram.sv ====
// synchronous pipelined burst sram, 64k words of 18 bits
//
// Summary of operation
// - all inputs but output enable registered
// - array of 65536 words by 18 bits
// - 2-bit counter alters only address bits 1:0
// - low/high write enables gate bits 8:0, 17:9
// - write starts on edge, self-timed internally
// - cpu strobe with select: read, abort burst
// - cache strobe: abort, load, read or write
// - chip enable checked only on address loads
// - advance ignored on address load cycle
// - advance low steps counter before access
// - advance high repeats access, wait state
// - burst wraps to loaded low bits
// - cache strobe with write enable: write
// - strobes high, advance low: next address
// - strobes high, advance high: same address
// - drive data only on read, oe low
// - data pins float after power-up
// - write enable low makes oe irrelevant
`timescale 1ns/100ps
`include "sbc_regs.svh"
module sbc_sram (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [`SBC_ADDR_W-1:0] addr,
    input wire logic chip_en_n,
    input wire logic cpu_addr_strobe_n,
    input wire logic cache_ctl_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic low_byte_wr_n,
    input wire logic high_byte_wr_n,
    input wire logic out_en_n,
    input wire logic [`SBC_DATA_W-1:0] dq_in,
    output logic [`SBC_DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic rd_accept
);
    // input capture stage
    logic [`SBC_ADDR_W-1:0] addr_r;
    logic [`SBC_ADDR_W-1:0] addr_nxt;
    logic [`SBC_DATA_W-1:0] din_r;
    logic [`SBC_DATA_W-1:0] din_nxt;
    logic ce_n_r;
    logic ce_n_nxt;
    logic sp_n_r;
    logic sp_n_nxt;
    logic sc_n_r;
    logic sc_n_nxt;
    logic adv_n_r;
    logic adv_n_nxt;
    logic [`SBC_LANES-1:0] wr_n_r;
    logic [`SBC_LANES-1:0] wr_n_nxt;

    // burst state
    sbc_pkg::sbc_st_t st_r;
    sbc_pkg::sbc_st_t st_nxt;
    logic [`SBC_ADDR_W-1:0] base_r;
    logic [`SBC_ADDR_W-1:0] base_nxt;
    logic [`SBC_CNT_W-1:0] cnt_r;
    logic [`SBC_CNT_W-1:0] cnt_nxt;

    // access stage
    sbc_pkg::sbc_op_t op;
    logic [`SBC_ADDR_W-1:0] acc_addr;
    logic do_rd;
    logic do_wr;
    logic [`SBC_LANES-1:0] lane_we;

    // read stage and pin drive
    logic [`SBC_DATA_W-1:0] rd_word_r;
    logic [`SBC_DATA_W-1:0] rd_word_nxt;
    logic rd_push_r;
    logic rd_push_nxt;
    logic drv_r;
    logic drv_nxt;
    logic accept_r;
    logic accept_nxt;
    logic oe_arm_r;
    logic oe_arm_nxt;

    // array side
    logic rd_take;
    logic [`SBC_DATA_W-1:0] lane_rd;

    sbc_stream_if fill_if ();
    sbc_stream_if drain_if ();

    // any byte lane asked for a write; decode and pin drive share it
    function automatic logic wr_asked(input logic [`SBC_LANES-1:0] wr_n);
        wr_asked = ~(&wr_n);
    endfunction

    // decoding of one sampled cycle; used for access and for state
    function automatic sbc_pkg::sbc_op_t op_decode(
        input logic ce_n,
        input logic sp_n,
        input logic sc_n,
        input logic adv_n,
        input logic [`SBC_LANES-1:0] wr_n,
        input sbc_pkg::sbc_st_t st
    );
        logic any_wr;
        any_wr = wr_asked(wr_n);
        if (!sp_n || !sc_n) begin
            if (ce_n) begin
                op_decode = sbc_pkg::SBC_OP_DESEL;
            end else if (!sp_n) begin
                op_decode = sbc_pkg::SBC_OP_RD_EXT;
            end else if (any_wr) begin
                op_decode = sbc_pkg::SBC_OP_WR_EXT;
            end else begin
                op_decode = sbc_pkg::SBC_OP_RD_EXT;
            end
        end else if (st == sbc_pkg::SBC_ST_IDLE) begin
            // no burst since reset or deselect, nothing to continue
            op_decode = sbc_pkg::SBC_OP_NONE;
        end else if (!adv_n) begin
            op_decode = any_wr ? sbc_pkg::SBC_OP_WR_NEXT
                : sbc_pkg::SBC_OP_RD_NEXT;
        end else begin
            op_decode = any_wr ? sbc_pkg::SBC_OP_WR_CUR
                : sbc_pkg::SBC_OP_RD_CUR;
        end
    endfunction

    function automatic logic op_is_write(input sbc_pkg::sbc_op_t o);
        case (o)
            sbc_pkg::SBC_OP_WR_EXT,
            sbc_pkg::SBC_OP_WR_NEXT,
            sbc_pkg::SBC_OP_WR_CUR: op_is_write = 1'b1;
            default: op_is_write = 1'b0;
        endcase
    endfunction

    // reads of all three kinds fill the read stage
    function automatic logic op_is_read(input sbc_pkg::sbc_op_t o);
        case (o)
            sbc_pkg::SBC_OP_RD_EXT,
            sbc_pkg::SBC_OP_RD_NEXT,
            sbc_pkg::SBC_OP_RD_CUR: op_is_read = 1'b1;
            default: op_is_read = 1'b0;
        endcase
    endfunction

    // input registers, noninverting
    always_comb begin
        addr_nxt = addr;
        din_nxt = dq_in;
        ce_n_nxt = chip_en_n;
        sp_n_nxt = cpu_addr_strobe_n;
        sc_n_nxt = cache_ctl_addr_strobe_n;
        adv_n_nxt = burst_step_n;
        wr_n_nxt = {high_byte_wr_n, low_byte_wr_n};
    end

    // strobes reset inactive so no access fires out of reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_r <= `SBC_BASE_RST;
            din_r <= `SBC_WORD_RST;
            ce_n_r <= 1'b1;
            sp_n_r <= 1'b1;
            sc_n_r <= 1'b1;
            adv_n_r <= 1'b1;
            wr_n_r <= 2'h3;
        end else begin
            addr_r <= addr_nxt;
            din_r <= din_nxt;
            ce_n_r <= ce_n_nxt;
            sp_n_r <= sp_n_nxt;
            sc_n_r <= sc_n_nxt;
            adv_n_r <= adv_n_nxt;
            wr_n_r <= wr_n_nxt;
        end
    end

    // burst control
    always_comb begin
        op = op_decode(ce_n_r, sp_n_r, sc_n_r, adv_n_r, wr_n_r, st_r);
        st_nxt = st_r;
        base_nxt = base_r;
        cnt_nxt = cnt_r;
        case (op)
            sbc_pkg::SBC_OP_DESEL: begin
                st_nxt = sbc_pkg::SBC_ST_IDLE;
            end
            sbc_pkg::SBC_OP_RD_EXT,
            sbc_pkg::SBC_OP_WR_EXT: begin
                // a new load aborts any burst; advance not looked at
                st_nxt = sbc_pkg::SBC_ST_BURST;
                base_nxt = addr_r;
                cnt_nxt = `SBC_CNT_RST;
            end
            sbc_pkg::SBC_OP_RD_NEXT,
            sbc_pkg::SBC_OP_WR_NEXT: begin
                // plain 2-bit add wraps after the fourth address
                cnt_nxt = cnt_r + 2'h1;
            end
            default: begin
                cnt_nxt = cnt_r;
            end
        endcase
        // counter never carries into bits above 1
        acc_addr = {base_nxt[`SBC_ADDR_W-1:`SBC_CNT_W],
            base_nxt[`SBC_CNT_W-1:0] ^ cnt_nxt};
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= sbc_pkg::SBC_ST_IDLE;
            base_r <= `SBC_BASE_RST;
            cnt_r <= `SBC_CNT_RST;
        end else begin
            st_r <= st_nxt;
            base_r <= base_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // array access; a read is refused while the read stage is held and the buffer is full
    always_comb begin
        do_wr = op_is_write(op);
        do_rd = op_is_read(op);
        // a read the held stage cannot take is lost; rd_accept warns
        rd_take = do_rd && (!rd_push_r || fill_if.ready);
    end

    // one array per byte lane, so each lane has a single writer
    generate
        for (genvar g = 0; g < `SBC_LANES; g++) begin : g_lane
            logic [`SBC_LANE_W-1:0] lane_mem [`SBC_DEPTH];

            assign lane_we[g] = do_wr & ~wr_n_r[g];
            assign lane_rd[g*`SBC_LANE_W +: `SBC_LANE_W] = lane_mem[acc_addr];

            // write completes inside this one edge, no external pulse
            always_ff @(posedge ref_clk) begin
                if (lane_we[g]) begin
                    lane_mem[acc_addr] <= din_r[g*`SBC_LANE_W +: `SBC_LANE_W];
                end
            end
        end
    endgenerate

    always_comb begin
        rd_word_nxt = rd_word_r;
        rd_push_nxt = rd_push_r & ~fill_if.ready;
        if (rd_take) begin
            rd_word_nxt = lane_rd;
            rd_push_nxt = 1'b1;
        end
        // writes and deselects let go of the pins
        drv_nxt = drv_r;
        if (do_wr || op == sbc_pkg::SBC_OP_DESEL) begin
            drv_nxt = 1'b0;
        end else if (do_rd) begin
            drv_nxt = 1'b1;
        end
        accept_nxt = ~rd_push_nxt | fill_if.ready;
        // arm is a flop; only out_en_n reaches the pins untimed
        oe_arm_nxt = drv_nxt & ~wr_asked(wr_n_nxt);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_word_r <= `SBC_WORD_RST;
            rd_push_r <= 1'b0;
            drv_r <= 1'b0;
            oe_arm_r <= 1'b0;
            accept_r <= 1'b1;
        end else begin
            rd_word_r <= rd_word_nxt;
            rd_push_r <= rd_push_nxt;
            drv_r <= drv_nxt;
            oe_arm_r <= oe_arm_nxt;
            accept_r <= accept_nxt;
        end
    end

    assign fill_if.valid = rd_push_r;
    assign fill_if.data = rd_word_r;
    assign drain_if.ready = rd_ready;

    sbc_buf u_buf (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .wr_side(fill_if),
        .rd_side(drain_if)
    );

    assign dq_out = drain_if.data;
    assign rd_valid = drain_if.valid;
    assign rd_accept = accept_r;
    // output enable must act without the clock, so this one is gated
    assign dq_oe = oe_arm_r & drain_if.valid & ~out_en_n;
endmodule

// ==== sbc_sram_props.sv ====
// concurrent checks on the burst cache sram ports
`timescale 1ns/100ps
`include "sbc_regs.svh"
module sbc_sram_props (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [`SBC_ADDR_W-1:0] addr,
    input wire logic chip_en_n,
    input wire logic cpu_addr_strobe_n,
    input wire logic cache_ctl_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic low_byte_wr_n,
    input wire logic high_byte_wr_n,
    input wire logic out_en_n,
    input wire logic [`SBC_DATA_W-1:0] dq_in,
    input wire logic [`SBC_DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic rd_accept
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic wr_any;
    assign wr_any = !low_byte_wr_n || !high_byte_wr_n;
    sequence s_cpu_rd;
        !chip_en_n && !cpu_addr_strobe_n && rd_accept;
    endsequence
    sequence s_cc_rd;
        !chip_en_n && cpu_addr_strobe_n && !cache_ctl_addr_strobe_n && !wr_any && rd_accept;
    endsequence
    sequence s_cc_wr;
        !chip_en_n && cpu_addr_strobe_n && !cache_ctl_addr_strobe_n && wr_any;
    endsequence
    sequence s_desel;
        chip_en_n && (!cpu_addr_strobe_n || !cache_ctl_addr_strobe_n);
    endsequence
    a_oe_needs_word: assert property (dq_oe |-> rd_valid && !out_en_n)
        else $error("data driven without a held read word");
    a_oe_async_off: assert property (out_en_n |-> !dq_oe)
        else $error("data driven with output enable high");
    a_wr_floats: assert property (wr_any |=> !dq_oe)
        else $error("data driven after a write enable");
    a_cpu_rd_word: assert property (s_cpu_rd |-> ##[1:3] rd_valid)
        else $error("cpu strobe read gave no word");
    a_cc_rd_word: assert property (s_cc_rd |-> ##[1:3] rd_valid)
        else $error("cache strobe read gave no word");
    a_cc_wr_float: assert property (s_cc_wr |=> !dq_oe [*2])
        else $error("data driven around a cache strobe write");
    a_desel_float: assert property (s_desel |-> ##2 !dq_oe)
        else $error("data driven after deselect");
    a_word_stands: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(dq_out))
        else $error("held read word changed while stalled");
    a_full_only: assert property (!rd_accept |-> rd_valid)
        else $error("reads refused with empty buffer");
endmodule
bind sbc_sram sbc_sram_props u_props (
    .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .chip_en_n(chip_en_n),
    .cpu_addr_strobe_n(cpu_addr_strobe_n), .cache_ctl_addr_strobe_n(cache_ctl_addr_strobe_n),
    .burst_step_n(burst_step_n), .low_byte_wr_n(low_byte_wr_n),
    .high_byte_wr_n(high_byte_wr_n), .out_en_n(out_en_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_accept(rd_accept)
);

// ==== sbc_rd_sink.sv ====
// read word receiver: prompt, stalled or random-ready
`timescale 1ns/100ps
`include "sbc_regs.svh"
module sbc_rd_sink (
    input wire logic ref_clk,
    input wire logic rd_valid,
    input wire logic [`SBC_DATA_W-1:0] dq_out,
    input wire logic [1:0] mode,
    output logic rd_ready,
    output logic pop_v,
    output logic [`SBC_DATA_W-1:0] pop_data
);
    initial rd_ready = 1'b0;
    // moves off the sampling edge only
    always @(negedge ref_clk) begin
        rd_ready <= (mode == 2'h0) | ((mode == 2'h2) & ($urandom_range(1, 0) == 1));
    end
    assign pop_v = rd_valid & rd_ready;
    assign pop_data = dq_out;
endmodule

// ==== testbench.sv ====
// self-checking bench for the burst cache sram
`timescale 1ns/100ps
`include "sbc_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module testbench;
    localparam logic [5:0] idle_c = 6'b110111;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] addr, base, b, a;
    logic chip_en_n, cpu_addr_strobe_n, cache_ctl_addr_strobe_n, burst_step_n;
    logic low_byte_wr_n, high_byte_wr_n, out_en_n, dq_oe, rd_valid, rd_ready, rd_accept;
    logic [17:0] dq_in, dq_out, bus_dq, pop_data;
    logic [17:0] mem [logic [15:0]];
    logic [17:0] exp_q[$], got_q[$];
    logic [1:0] cnt, mode;
    logic pop_v, live;
    int checks = 0;
    int error_cnt = 0;
    assign dq_in = dq_oe ? dq_out : bus_dq;
    always #4 ref_clk = ~ref_clk;
    sbc_sram uut (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .chip_en_n(chip_en_n),
        .cpu_addr_strobe_n(cpu_addr_strobe_n), .cache_ctl_addr_strobe_n(cache_ctl_addr_strobe_n),
        .burst_step_n(burst_step_n), .low_byte_wr_n(low_byte_wr_n),
        .high_byte_wr_n(high_byte_wr_n), .out_en_n(out_en_n), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_accept(rd_accept));
    sbc_rd_sink u_sink (.ref_clk(ref_clk), .rd_valid(rd_valid), .dq_out(dq_out), .mode(mode),
        .rd_ready(rd_ready), .pop_v(pop_v), .pop_data(pop_data));
    always @(posedge ref_clk) if (pop_v === 1'b1) got_q.push_back(pop_data);
    function automatic logic [15:0] baddr(input logic [15:0] bs, input logic [1:0] c);
        return {bs[15:2], bs[1:0] ^ c};
    endfunction
    function automatic logic [17:0] merge(input logic [17:0] o, n, input logic lw, hw);
        return {hw ? o[17:9] : n[17:9], lw ? o[8:0] : n[8:0]};
    endfunction
    // c = {chip enable, cpu strobe, cache strobe, advance, low wr, high wr}
    task automatic cyc(input logic [5:0] c, input logic [15:0] ad, input logic [17:0] d);
        logic [15:0] ea;
        logic wr;
        {chip_en_n, cpu_addr_strobe_n, cache_ctl_addr_strobe_n} = c[5:3];
        {burst_step_n, low_byte_wr_n, high_byte_wr_n} = c[2:0];
        addr = ad;
        wr = ~(c[1] & c[0]);
        bus_dq = wr ? d : ~bus_dq;
        out_en_n = wr;
        if (!c[4] || !c[3]) begin
            live = !c[5];
            base = ad;
            cnt = 2'h0;
            wr = wr & c[4];
        end else if (!c[2]) cnt = cnt + 2'h1;
        ea = baddr(base, cnt);
        if (live && wr) mem[ea] = merge(mem[ea], d, c[1], c[0]);
        else if (live) exp_q.push_back(mem[ea]);
        @(negedge ref_clk);
    endtask
    task automatic drain(input string nm);
        logic [17:0] e, g;
        int n;
        n = 0;
        repeat (6) @(negedge ref_clk);
        while (got_q.size() < exp_q.size() && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("word count", exp_q.size(), got_q.size())
        while (exp_q.size() > 0 && got_q.size() > 0) begin
            e = exp_q.pop_front();
            g = got_q.pop_front();
            `CHK("read word", e, g)
        end
        exp_q.delete();
        got_q.delete();
        $display("test %s done", nm);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h32e8));
        {live, cnt, base, bus_dq, mode} = '0;
        {addr, out_en_n} = {16'h0000, 1'b1};
        {chip_en_n, cpu_addr_strobe_n, cache_ctl_addr_strobe_n} = 3'b110;
        {burst_step_n, low_byte_wr_n, high_byte_wr_n} = 3'b111;
        repeat (3) @(negedge ref_clk);
        `CHK("reset oe", 1'b0, dq_oe)
        `CHK("reset valid", 1'b0, rd_valid)
        `CHK("reset accept", 1'b1, rd_accept)
        reset_n = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            b = 16'($urandom);
            cyc({3'b010, 1'($urandom_range(1, 0)), 2'b00}, b, 18'($urandom));
            cyc(6'b111000, ~b, 18'($urandom));
            cyc(6'b011100, ~b, 18'($urandom));
            repeat (2) cyc(6'b011000, ~b, 18'($urandom));
            cyc({4'b0110, 2'($urandom)}, b, 18'($urandom));
            cyc(6'b010111, b, 18'h00000);
            repeat (5) cyc(6'b011011, ~b, 18'h00000);
            cyc(6'b011111, ~b, 18'h00000);
            a = {b[15:2], 2'($urandom)};
            cyc(6'b001000, a, 18'($urandom));
            cyc(6'b011100, ~b, 18'($urandom));
            cyc(6'b001111, a, 18'h00000);
            cyc(6'b110100, a, 18'($urandom));
            cyc(6'b011000, ~b, 18'($urandom));
            cyc(6'b001111, a, 18'h00000);
            mode = 2'h2;
            cyc(idle_c, b, 18'h00000);
            drain("burst");
            mode = 2'h0;
        end
        mode = 2'h1;
        cyc(6'b001111, a, 18'h00000);
        repeat (3) cyc(idle_c, b, 18'h00000);
        `CHK("held word", 1'b1, rd_valid)
        // reads keep the pins owned; a deselect would float them
        repeat (3) cyc(6'b001111, a, 18'h00000);
        out_en_n = 1'b1;
        #1 `CHK("oe off", 1'b0, dq_oe)
        out_en_n = 1'b0;
        #1 `CHK("bus word", exp_q[0], dq_in)
        repeat (2) cyc(idle_c, b, 18'h00000);
        `CHK("full refuse", 1'b0, rd_accept)
        `CHK("desel float", 1'b0, dq_oe)
        // stall fills buffer and stage, the newest read is lost
        void'(exp_q.pop_back());
        mode = 2'h0;
        drain("fill");
        give_verdict();
    end
endmodule
